// *** hw/tsdiag_top.sv ***
/*
 * Touch status, host attention and power-up self-test logic.
 * Assumes an external byte register port on CLK (from an I2C slave), an
 * external non-volatile store and a measurement engine on CLK; raw touch
 * levels come from the sensing front end and are synchronised here.
 */
`include "tsdiag_params.svh"

module tsdiag_top import tsdiag_pkg::*; #(
    parameter int N = TSD_NUM_SENS,
    parameter int unsigned DIAG_PULSE_CYC = `TSD_DIAG_PULSE_CYC,
    parameter int unsigned ATTN_PULSE_CYC = `TSD_ATTN_PULSE_CYC,
    parameter int unsigned REFRESH_CYC = `TSD_REFRESH_CYC,
    parameter tsd_cfg_s FACTORY_CFG = '0
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [N-1:0] TOUCH_RAW,
    input wire logic DIAG_VALID,
    input wire logic [N*8-1:0] DIAG_CP_PF,
    input wire logic [N-1:0] DIAG_SHORT_GND,
    input wire logic [N-1:0] DIAG_SHORT_VDD,
    input wire logic [N-1:0] DIAG_SHORT_SENS,
    input wire logic [N-1:0] DIAG_SHORT_SHIELD,
    input wire logic DIAG_SHIELD_FAIL,
    input wire logic [15:0] DIAG_MODULATION_CAPACITOR_PF,
    input wire logic NVM_USER_VALID,
    input wire tsd_cfg_s NVM_USER_CFG,
    input wire logic NVM_BACKUP_VALID,
    input wire tsd_cfg_s NVM_BACKUP_CFG,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic NVM_SAVE,
    output tsd_cfg_s NVM_SAVE_CFG,
    output logic [1:0] ATTN_O,
    output logic [1:0] ATTN_OE,
    output logic [N-1:0] SENS_OUT_O,
    output logic [N-1:0] SENS_OUT_OE,
    output logic BOOT_DONE
);

    // ======================================================================
    // Elaboration checks
    // ======================================================================
    if (N != TSD_NUM_SENS) begin : g_bad_n
        $error("N must equal the configuration field width");
    end
    if (DIAG_PULSE_CYC < 1 || ATTN_PULSE_CYC < 1 || REFRESH_CYC <= ATTN_PULSE_CYC) begin : g_bad_t
        $error("Timing counts out of range");
    end

    // ======================================================================
    // State
    // ======================================================================
    tsd_state_e state;
    tsd_cfg_s cfg;
    logic [7:0] shadow [0:126];
    logic [N-1:0] touch_m, touch_s;
    logic [N-1:0] fail_sens, disabled, report, latched;
    logic shield_fail, modulation_capacitor_fail, diag_done;
    logic [31:0] pulse_cnt, attn_cnt, holdoff;
    logic attn_pending;
    logic [2:0] owner;
    logic owner_valid;
    logic [7:0] cmd_status;

    // Two-flop synchroniser on raw touch levels
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            touch_m <= '0;
            touch_s <= '0;
        end else if (CE) begin
            touch_m <= TOUCH_RAW;
            touch_s <= touch_m;
        end
    end

    // ======================================================================
    // Self-test evaluation
    // ======================================================================
    logic [N-1:0] sens_bad;
    for (genvar i = 0; i < N; i++) begin : g_diag
        assign sens_bad[i] = (DIAG_CP_PF[i*8 +: 8] > `TSD_CP_MAX_PF)
            | DIAG_SHORT_GND[i] | DIAG_SHORT_VDD[i]
            | DIAG_SHORT_SENS[i] | DIAG_SHORT_SHIELD[i];
    end
    wire modulation_capacitor_bad = (DIAG_MODULATION_CAPACITOR_PF < `TSD_MODULATION_CAPACITOR_MIN_PF)
        || (DIAG_MODULATION_CAPACITOR_PF > `TSD_MODULATION_CAPACITOR_MAX_PF);
    wire all_bad = DIAG_SHIELD_FAIL || modulation_capacitor_bad;
    wire [N-1:0] next_fail = all_bad ? '1 : sens_bad;

    // Boot source selection: user, then last valid, then factory
    wire tsd_cfg_s boot_cfg = NVM_USER_VALID ? NVM_USER_CFG
        : (NVM_BACKUP_VALID ? NVM_BACKUP_CFG : FACTORY_CFG);

    // Boot sequencer: load, wait results, pulse failures, run
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= ST_LOAD;
            cfg <= '0;
            fail_sens <= '0;
            disabled <= '0;
            shield_fail <= 1'b0;
            modulation_capacitor_fail <= 1'b0;
            diag_done <= 1'b0;
            pulse_cnt <= '0;
            BOOT_DONE <= 1'b0;
        end else if (CE) begin
            unique case (state)
                ST_LOAD: begin
                    cfg <= boot_cfg;
                    state <= ST_WAIT_DIAG;
                end
                ST_WAIT_DIAG: begin
                    if (DIAG_VALID) begin
                        fail_sens <= next_fail;
                        disabled <= next_fail;
                        shield_fail <= DIAG_SHIELD_FAIL;
                        modulation_capacitor_fail <= modulation_capacitor_bad;
                        diag_done <= 1'b1;
                        pulse_cnt <= DIAG_PULSE_CYC;
                        state <= (|next_fail) ? ST_PULSE : ST_RUN;
                        BOOT_DONE <= ~(|next_fail);
                    end
                end
                ST_PULSE: begin
                    pulse_cnt <= pulse_cnt - 32'h00000001;
                    // Boot ends a cycle after the last pulse cycle, never during it
                    if (pulse_cnt == 32'h00000001) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    BOOT_DONE <= 1'b1;
                end
            endcase
        end
    end

    // ======================================================================
    // Reported status with neighbour suppression
    // ======================================================================
    function automatic logic [2:0] lowest(input logic [N-1:0] v);
        lowest = 3'h0;
        for (int k = N - 1; k >= 0; k--) begin
            if (v[k]) begin
                lowest = k[2:0];
            end
        end
    endfunction

    wire run = (state == ST_RUN);
    wire [N-1:0] live = run ? (touch_s & ~disabled) : '0;
    wire [N-1:0] fss_live = live & cfg.neighbour_touch_suppression;
    wire keep_owner = owner_valid && fss_live[owner];
    wire next_owner_valid = keep_owner || (|fss_live);
    wire [2:0] next_owner = keep_owner ? owner : lowest(fss_live);
    wire [N-1:0] owner_bit = next_owner_valid ? (N'(1) << next_owner) : '0;
    wire [N-1:0] next_report = (live & ~cfg.neighbour_touch_suppression) | owner_bit;

    // Status registers and latched touches; a new touch wins over a clear
    wire rd_latched = REG_RD && (REG_ADDR == `TSD_STAT_LATCHED);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            owner <= 3'h0;
            owner_valid <= 1'b0;
            report <= '0;
            latched <= '0;
        end else if (CE) begin
            owner <= next_owner;
            owner_valid <= next_owner_valid;
            report <= next_report;
            latched <= (rd_latched ? '0 : latched) | report;
        end
    end

    // ======================================================================
    // Host attention pulse
    // ======================================================================
    wire changed = (next_report != report);
    wire attn_start = (attn_pending || changed) && (holdoff == 32'h0);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            attn_pending <= 1'b0;
            attn_cnt <= '0;
            holdoff <= '0;
        end else if (CE) begin
            // A change served by the pulse starting now leaves nothing pending
            attn_pending <= (changed || attn_pending) && !attn_start;
            if (attn_start) begin
                attn_cnt <= ATTN_PULSE_CYC;
                holdoff <= REFRESH_CYC;
            end else begin
                attn_cnt <= (attn_cnt != 32'h0) ? attn_cnt - 32'h00000001 : attn_cnt;
                holdoff <= (holdoff != 32'h0) ? holdoff - 32'h00000001 : holdoff;
            end
        end
    end

    // ======================================================================
    // Open-drain pin drive
    // ======================================================================
    wire attn_on = attn_start || (attn_cnt > 32'h00000001);
    wire [1:0] next_attn_oe = attn_on ? (2'h1 << cfg.attn_sel) : 2'h0;
    wire [N-1:0] next_sens_oe = (state == ST_PULSE) ? fail_sens
        : (report & cfg.sensor_ctl);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ATTN_O <= 2'h0;
            ATTN_OE <= 2'h0;
            SENS_OUT_O <= '0;
            SENS_OUT_OE <= '0;
        end else if (CE) begin
            ATTN_O <= 2'h0;
            ATTN_OE <= next_attn_oe;
            SENS_OUT_O <= '0;
            SENS_OUT_OE <= next_sens_oe;
        end
    end

    // ======================================================================
    // Register port
    // ======================================================================
    wire wr_cfg = REG_WR && (REG_ADDR <= `TSD_CFG_LAST);
    wire wr_cmd = REG_WR && (REG_ADDR >= `TSD_CMD_FIRST) && (REG_ADDR <= `TSD_CMD_LAST);
    wire wr_save = wr_cmd && (REG_ADDR == `TSD_CMD_CTRL) && (REG_WDATA == `TSD_CMD_SAVE);
    wire tsd_cfg_s shadow_cfg = '{neighbour_touch_suppression: shadow[0], sensor_ctl: shadow[1],
        attn_sel: shadow[2][0]};
    wire [7:0] diag_sys = {5'h00, diag_done, modulation_capacitor_fail, shield_fail};
    wire [7:0] next_rdata =
        (REG_ADDR <= `TSD_CFG_LAST) ? shadow[REG_ADDR[6:0]]
        : (REG_ADDR == `TSD_STAT_CUR) ? report
        : (REG_ADDR == `TSD_STAT_LATCHED) ? (latched | report)
        : (REG_ADDR == `TSD_STAT_DIAG_SENS) ? fail_sens
        : (REG_ADDR == `TSD_STAT_DIAG_SYS) ? diag_sys
        : (REG_ADDR == `TSD_STAT_CMD) ? cmd_status
        : 8'h00;

    // Shadow configuration, commands and read data; status is never written
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int a = 0; a < 127; a++) begin
                shadow[a] <= 8'h00;
            end
            cmd_status <= `TSD_CMD_OK;
            NVM_SAVE <= 1'b0;
            NVM_SAVE_CFG <= '0;
            REG_RDATA <= 8'h00;
        end else if (CE) begin
            if (state == ST_LOAD) begin
                shadow[0] <= boot_cfg.neighbour_touch_suppression;
                shadow[1] <= boot_cfg.sensor_ctl;
                shadow[2] <= {7'h00, boot_cfg.attn_sel};
            end else if (wr_cfg) begin
                shadow[REG_ADDR[6:0]] <= REG_WDATA;
            end
            NVM_SAVE <= wr_save;
            if (wr_save) begin
                NVM_SAVE_CFG <= shadow_cfg;
            end
            if (wr_cmd) begin
                cmd_status <= wr_save ? `TSD_CMD_OK : `TSD_CMD_BAD;
            end
            if (REG_RD) begin
                REG_RDATA <= next_rdata;
            end
        end
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    a_attn_low_only: assert property (@(posedge CLK) disable iff (!RESETN)
        ATTN_O == 2'h0) else $error("Attention pin drives high");
    a_attn_one_pin: assert property (@(posedge CLK) disable iff (!RESETN)
        ATTN_OE != 2'h0 |-> $onehot(ATTN_OE)) else $error("Two attention pins");
    a_latch_keeps: assert property (@(posedge CLK) disable iff (!RESETN)
        CE && report[0] |=> latched[0]) else $error("Touch not latched");
    a_latch_clears: assert property (@(posedge CLK) disable iff (!RESETN)
        CE && rd_latched && report == '0 |=> latched == '0) else $error("Latch not cleared");
    a_fss_single: assert property (@(posedge CLK) disable iff (!RESETN)
        $onehot0(report & cfg.neighbour_touch_suppression)) else $error("Two suppressed buttons on");
    a_fail_pulse: assert property (@(posedge CLK) disable iff (!RESETN)
        CE && state == ST_PULSE |=> SENS_OUT_OE == fail_sens) else $error("Fail pulse wrong");
    a_all_fail: assert property (@(posedge CLK) disable iff (!RESETN)
        diag_done && (shield_fail || modulation_capacitor_fail) |-> disabled == '1) else $error("Not all off");
    a_boot_order: assert property (@(posedge CLK) disable iff (!RESETN)
        BOOT_DONE |-> state == ST_RUN) else $error("Boot done during pulse");
    a_disabled_quiet: assert property (@(posedge CLK) disable iff (!RESETN)
        (report & disabled) == '0) else $error("Disabled sensor reported");
    a_save_next: assert property (@(posedge CLK) disable iff (!RESETN)
        CE && wr_save |=> NVM_SAVE && NVM_SAVE_CFG == $past(shadow_cfg)) else $error("Save lost");
    a_attn_spacing: assert property (@(posedge CLK) disable iff (!RESETN)
        CE && attn_start |=> holdoff == REFRESH_CYC && !attn_start) else $error("Pulse spacing");

endmodule : tsdiag_top

// *** include/tsdiag_params.svh ***
/*
 * Constants of the touch status and diagnostics block: register offsets,
 * command codes, self-test limits and timing.
 * Assumes a 250 MHz core clock and a byte-wide register port.
 */
`ifndef TSDIAG_PARAMS_SVH
`define TSDIAG_PARAMS_SVH

// ==========================================================================
// Clock
// ==========================================================================
`define TSD_CLK_KHZ 250000

// ==========================================================================
// Register ranges and offsets
// ==========================================================================
`define TSD_CFG_LAST 8'h7E
`define TSD_CMD_FIRST 8'h80
`define TSD_CMD_LAST 8'h87
`define TSD_STAT_FIRST 8'h88
`define TSD_STAT_LAST 8'hFB
`define TSD_CFG_FSS 8'h00
`define TSD_CFG_SENSCTL 8'h01
`define TSD_CFG_ATTNSEL 8'h02
`define TSD_CMD_CTRL 8'h80
`define TSD_STAT_CUR 8'h88
`define TSD_STAT_LATCHED 8'h89
`define TSD_STAT_DIAG_SENS 8'h8A
`define TSD_STAT_DIAG_SYS 8'h8B
`define TSD_STAT_CMD 8'h8C

// ==========================================================================
// Commands and command status
// ==========================================================================
`define TSD_CMD_SAVE 8'h02
`define TSD_CMD_OK 8'h00
`define TSD_CMD_BAD 8'hFD

// ==========================================================================
// Self-test limits (45 pF, 1 nF = 1000 pF, 4 nF = 4000 pF)
// ==========================================================================
`define TSD_CP_MAX_PF 8'h2D
`define TSD_MODULATION_CAPACITOR_MIN_PF 16'h03E8
`define TSD_MODULATION_CAPACITOR_MAX_PF 16'h0FA0

// ==========================================================================
// Timing
// ==========================================================================
`define TSD_DIAG_PULSE_MS 50
`define TSD_DIAG_PULSE_CYC (`TSD_DIAG_PULSE_MS * `TSD_CLK_KHZ)
`define TSD_ATTN_PULSE_CYC 250
`define TSD_REFRESH_CYC 25000

`endif

// *** include/tsdiag_pkg.sv ***
/*
 * Types shared by the touch status and diagnostics block.
 * Assumes eight sensor channels.
 */
package tsdiag_pkg;

    // ======================================================================
    // Sizes
    // ======================================================================
    localparam int TSD_NUM_SENS = 8;

    // ======================================================================
    // Active configuration
    // ======================================================================
    typedef struct packed {
        logic [7:0] neighbour_touch_suppression;
        logic [7:0] sensor_ctl;
        logic attn_sel;
    } tsd_cfg_s;

    // ======================================================================
    // Boot and run phases
    // ======================================================================
    typedef enum logic [1:0] {
        ST_LOAD,
        ST_WAIT_DIAG,
        ST_PULSE,
        ST_RUN
    } tsd_state_e;

endpackage : tsdiag_pkg

// *** sim/tsd_host_model.sv ***
/*
 * Host side model: register port driver, attention pull-ups, status service.
 * Assumes one caller process at a time and the block's byte register port.
 */
module tsd_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] attn_o,
    input wire logic [1:0] attn_oe,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic [1:0] attn_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pull-up on each attention pin, low only while the block drives it
    assign attn_line[0] = attn_oe[0] ? attn_o[0] : 1'b1;
    assign attn_line[1] = attn_oe[1] ? attn_o[1] : 1'b1;

    // Idle port at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One byte write; released lines show the inverse value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    // One byte read, data taken once the answer stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask : rd

    // Answer to an attention pulse: current then latched status
    task automatic answer(output logic [7:0] cur, output logic [7:0] lat);
        rd(8'h88, cur);
        rd(8'h89, lat);
    endtask : answer
endmodule : tsd_host_model

// *** sim/tb_top.sv ***
/*
 * Bench of the touch status block: self-test, touch report, attention, registers.
 * Assumes the host model owns the register port; short pulse and holdoff counts.
 */
`include "tsdiag_params.svh"
module tb_top import tsdiag_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSE = 20;
    logic clk, resetn, diag_valid, user_ok, backup_ok, shield_fail, reg_wr, reg_rd;
    logic nvm_save, boot_done, p1;
    logic [7:0] touch, s_gnd, s_vdd, s_sens, s_shd, addr, wdata, rdata, sens_o, sens_oe, cur, lat;
    logic [1:0] attn_o, attn_oe, attn_line;
    logic [63:0] cp;
    logic [15:0] modulation_capacitor;
    tsd_cfg_s user_cfg, backup_cfg, save_cfg;
    int err_count, n_compared, n_rise0, n_low1, n_bad;
    int cyc;
    int rise1[$];

    tsdiag_top #(.DIAG_PULSE_CYC(PULSE), .ATTN_PULSE_CYC(3), .REFRESH_CYC(10)) i_tsdiag_top (
        .CLK(clk), .RESETN(resetn), .CE(1'b1), .TOUCH_RAW(touch), .DIAG_VALID(diag_valid),
        .DIAG_CP_PF(cp), .DIAG_SHORT_GND(s_gnd), .DIAG_SHORT_VDD(s_vdd),
        .DIAG_SHORT_SENS(s_sens), .DIAG_SHORT_SHIELD(s_shd), .DIAG_SHIELD_FAIL(shield_fail),
        .DIAG_MODULATION_CAPACITOR_PF(modulation_capacitor), .NVM_USER_VALID(user_ok), .NVM_USER_CFG(user_cfg),
        .NVM_BACKUP_VALID(backup_ok), .NVM_BACKUP_CFG(backup_cfg), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .NVM_SAVE(nvm_save), .NVM_SAVE_CFG(save_cfg), .ATTN_O(attn_o), .ATTN_OE(attn_oe),
        .SENS_OUT_O(sens_o), .SENS_OUT_OE(sens_oe), .BOOT_DONE(boot_done));
    tsd_host_model i_tsd_host_model (.clk(clk), .reg_rdata(rdata), .attn_o(attn_o),
        .attn_oe(attn_oe), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
        .reg_wdata(wdata), .attn_line(attn_line));

    // ======================================================================
    // Clock, monitors, compare and verdict
    // ======================================================================
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Attention pulse starts, low time and wrongly driven pins
    always @(negedge clk) begin
        cyc++;
        if (attn_oe[1] === 1'b1 && p1 !== 1'b1) rise1.push_back(cyc);
        p1 = attn_oe[1];
        if (attn_oe[0] === 1'b1) n_rise0++;
        if (attn_line[1] === 1'b0) n_low1++;
        if ((attn_oe & attn_o) !== 2'h0 || (sens_oe & sens_o) !== 8'h00) n_bad++;
    end

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // Self-test results with no fault at all
    task automatic clean();
        @(posedge clk);
        cp <= {8{8'h05}};
        {s_gnd, s_vdd, s_sens, s_shd} <= 32'h0;
        shield_fail <= 1'b0;
        modulation_capacitor <= 16'h0898;
    endtask : clean

    // Reset, hand over self-test results, time fail pulse and boot end
    task automatic boot(input logic [7:0] mask);
        int n;
        int np;
        np = 0;
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        diag_valid <= 1'b1;
        @(posedge clk);
        diag_valid <= 1'b0;
        for (n = 1; n <= 40; n++) begin
            @(posedge clk);
            #1;
            if (mask != 8'h00 && sens_oe === mask) np++;
            if (boot_done === 1'b1) break;
        end
        if (n > 40) begin
            err_count++;
            conclude();
        end
        cmp("boot cycles", (mask != 8'h00) ? 8'(PULSE + 1) : 8'h01, 8'(n));
        cmp("fail pulse cycles", (mask != 8'h00) ? 8'(PULSE) : 8'h00, 8'(np));
        @(posedge clk);
        #1;
        cmp("outputs after boot", 8'h00, sens_oe);
        rise1.delete();
        n_rise0 = 0;
        n_low1 = 0;
    endtask : boot

    // Apply a touch pattern and let it pass the synchroniser
    task automatic touch_wait(input logic [7:0] t);
        @(posedge clk);
        touch <= t;
        repeat (8) @(posedge clk);
        #1;
    endtask : touch_wait

    // ======================================================================
    // Scenarios
    // ======================================================================
    // Single sensor faults, boundary values pass, factory configuration
    task automatic s_sensor_fail();
        clean();
        user_ok <= 1'b0;
        backup_ok <= 1'b0;
        cp <= {40'h0505050505, 8'h2D, 8'h2E, 8'h05};
        modulation_capacitor <= 16'h03E8;
        s_gnd <= 8'h20;
        s_vdd <= 8'h40;
        s_sens <= 8'h02;
        s_shd <= 8'h80;
        boot(8'hE2);
        i_tsd_host_model.rd(8'h8A, cur);
        cmp("sensor fail mask", 8'hE2, cur);
        i_tsd_host_model.rd(8'h8B, cur);
        cmp("system result", 8'h04, cur);
        touch_wait(8'h07);
        cmp("factory outputs", 8'h00, sens_oe);
        i_tsd_host_model.rd(8'h88, cur);
        cmp("disabled sensors", 8'h05, cur);
        cmp("pin 0 attention", 8'h01, 8'(n_rise0 > 0));
        cmp("pin 1 silent", 8'h00, 8'(rise1.size()));
        touch_wait(8'h00);
    endtask : s_sensor_fail

    // Shield and modulation capacitor faults disable every sensor
    task automatic s_all_fail();
        logic [7:0] exp_sys[3] = '{8'h05, 8'h06, 8'h06};
        logic [15:0] cm[3] = '{16'h0898, 16'h03E7, 16'h0FA1};
        for (int k = 0; k < 3; k++) begin
            clean();
            shield_fail <= (k == 0);
            modulation_capacitor <= cm[k];
            boot(8'hFF);
            i_tsd_host_model.rd(8'h8B, cur);
            cmp("system result", exp_sys[k], cur);
            i_tsd_host_model.rd(8'h8A, cur);
            cmp("all sensors failed", 8'hFF, cur);
        end
    endtask : s_all_fail

    // Neighbour suppression, sensor outputs and attention spacing
    task automatic s_fss();
        clean();
        modulation_capacitor <= 16'h0FA0;
        user_ok <= 1'b1;
        user_cfg <= tsd_cfg_s'{8'h03, 8'h0F, 1'b1};
        backup_ok <= 1'b1;
        backup_cfg <= tsd_cfg_s'{8'h00, 8'hF0, 1'b0};
        boot(8'h00);
        touch_wait(8'h03);
        i_tsd_host_model.rd(8'h88, cur);
        cmp("one of neighbours", 8'h01, cur);
        cmp("sensor outputs", 8'h01, sens_oe);
        touch_wait(8'h07);
        cmp("sensor outputs", 8'h05, sens_oe);
        touch_wait(8'h00);
        repeat (20) @(posedge clk);
        cmp("pulse count", 8'h03, 8'(rise1.size()));
        for (int i = 1; i < rise1.size(); i++) begin
            cmp("pulse spacing", 8'h01, 8'(rise1[i] - rise1[i - 1] >= 10));
        end
        cmp("low time", 8'(3 * rise1.size()), 8'(n_low1));
        cmp("pin 0 silent", 8'h00, 8'(n_rise0));
        i_tsd_host_model.answer(cur, lat);
    endtask : s_fss

    // Missed touch shows in latched state only, then clears
    task automatic s_latch();
        touch_wait(8'h08);
        touch_wait(8'h00);
        i_tsd_host_model.answer(cur, lat);
        cmp("current", 8'h00, cur);
        cmp("latched", 8'h08, lat);
        i_tsd_host_model.answer(cur, lat);
        cmp("latched again", 8'h00, lat);
    endtask : s_latch

    // Write, command, read-only and save-then-reset behaviour
    task automatic s_regs();
        i_tsd_host_model.wr(8'h01, 8'h55);
        touch_wait(8'h02);
        cmp("live outputs", 8'h02, sens_oe);
        touch_wait(8'h00);
        i_tsd_host_model.wr(8'h80, 8'h02);
        #1;
        cmp("save strobe", 8'h01, 8'(nvm_save));
        cmp("saved control", 8'h55, save_cfg.sensor_ctl);
        @(posedge clk);
        #1;
        cmp("save strobe end", 8'h00, 8'(nvm_save));
        i_tsd_host_model.wr(8'h81, 8'h07);
        i_tsd_host_model.rd(8'h8C, cur);
        cmp("bad command", 8'hFD, cur);
        i_tsd_host_model.wr(8'h80, 8'h02);
        i_tsd_host_model.rd(8'h8C, cur);
        cmp("good command", 8'h00, cur);
        i_tsd_host_model.wr(8'h88, 8'hFF);
        i_tsd_host_model.rd(8'h88, cur);
        cmp("read-only status", 8'h00, cur);
        i_tsd_host_model.rd(8'hFE, cur);
        cmp("unmapped", 8'h00, cur);
        @(posedge clk);
        user_cfg <= save_cfg;
        boot(8'h00);
        touch_wait(8'h02);
        cmp("outputs after reset", 8'h00, sens_oe);
        touch_wait(8'h00);
    endtask : s_regs

    // Invalid user store falls back to the backup configuration
    task automatic s_fallback();
        @(posedge clk);
        user_ok <= 1'b0;
        boot(8'h00);
        touch_wait(8'h10);
        cmp("backup outputs", 8'h10, sens_oe);
        touch_wait(8'h00);
    endtask : s_fallback

    // Main sequence
    initial begin
        resetn = 1'b0;
        diag_valid = 1'b0;
        touch = 8'h00;
        user_ok = 1'b0;
        backup_ok = 1'b0;
        user_cfg = '0;
        backup_cfg = '0;
        p1 = 1'b0;
        clean();
        s_sensor_fail();
        s_all_fail();
        s_fss();
        s_latch();
        s_regs();
        s_fallback();
        cmp("wrongly driven pins", 8'h00, 8'(n_bad));
        conclude();
    end
endmodule : tb_top
